/* design/repeater_cfg_regs.sv */
// Configuration and status register bank of the one-port repeater.
// Assumes an I2C target engine that hands over each received data byte as a one-cycle
// write strobe, and asks for each byte to send with a one-cycle read strobe.
`default_nettype none

// How it works
// - Bank served in both bus modes, single or sequential.
// - Read-write fields return last written value.
// - Read-only fields ignore host writes.
// - Write-only reads carry no meaning, no action.
// - Read-as-zero fields read zero, ignore writes.
// - Set-only bits set by one, kept by zero.
// - Power-on reset loads every listed default.
// - Software reset restores writables, self-clears, reads zero.
// - Unmapped addresses read 0xFF, writes ignored.
// - Pointer advances per byte; overflow bytes discarded.
module repeater_cfg_regs
  import repeater_cfg_pkg::*;
#(
  parameter logic [7:0] STEP_CODE = 8'h5a,  // Arbitrary value.
  parameter logic [7:0] PART_LO_CODE = 8'h11,  // Arbitrary value.
  parameter logic [7:0] PART_MID_CODE = 8'h44,  // Arbitrary value.
  parameter logic [7:0] PART_HI_CODE = 8'h01  // Arbitrary value.
)
(
  input wire logic i_ref_clk,
  input wire logic i_rst_b,
  input wire logic i_ext_reset_b,
  input wire logic i_ptr_load,
  input wire logic [7:0] i_ptr_addr,
  input wire logic i_wr_stb,
  input wire logic [7:0] i_wr_data,
  input wire logic i_rd_stb,
  input wire logic [3:0] i_role_speed_state,
  input wire logic [2:0] i_conn_state,
  output logic [7:0] o_rd_data,
  output logic [7:0] o_ptr,
  output logic [7:0] o_role_speed_forcing,
  output logic [7:0] o_line_state_forcing,
  output logic [7:0] o_embedded_side_receive_tuning,
  output logic [7:0] o_embedded_side_transmit_tuning,
  output logic [7:0] o_legacy_side_receive_tuning,
  output logic [7:0] o_legacy_side_emphasis_tuning,
  output logic [7:0] o_legacy_side_edge_swing_tuning,
  output logic [7:0] o_legacy_side_termination_select,
  output logic [7:0] o_unplug_detect_level,
  output logic [7:0] o_remote_access_key,
  output logic [7:0] o_voltage_detect_switch
);

  // ----------------------------------------------------------------------
  // Register pointer
  // ----------------------------------------------------------------------
  logic [7:0] ptr_ff;
  logic [7:0] rw_ff [NUM_RW];
  logic soft_reset_ff;
  logic [7:0] role_rpt_ff;
  logic [7:0] conn_rpt_ff;
  logic [7:0] rd_data_ff;
  logic [7:0] nxt_rd_data;

  // Index of the writable register at an address, or NUM_RW when none.
  function automatic int rw_index(input logic [7:0] addr);
    int idx;
    idx = NUM_RW;
    for (int k = 0; k < NUM_RW; k++)
    begin
      if (RW_ADDR[k] == addr)
      begin
        idx = k;
      end
    end
    return idx;
  endfunction

  // The pointer saturates at 0xFF, well past the map, so that a long burst never wraps back
  // onto live registers.
  always_ff @(posedge i_ref_clk or negedge i_rst_b)
  begin
    if (!i_rst_b)
    begin
      ptr_ff <= ZERO_BYTE;
    end
    else if (i_ptr_load)
    begin
      ptr_ff <= i_ptr_addr;
    end
    else if ((i_wr_stb || i_rd_stb) && ptr_ff != 8'hff)
    begin
      ptr_ff <= ptr_ff + 8'h01;
    end
  end

  // ----------------------------------------------------------------------
  // Writable registers and software reset
  // ----------------------------------------------------------------------
  // The external reset pin returns writables to defaults in the cycle after it is sampled low,
  // a software reset one cycle later than its write; the request bit then reads zero again.
  always_ff @(posedge i_ref_clk or negedge i_rst_b)
  begin
    if (!i_rst_b)
    begin
      soft_reset_ff <= 1'b0;
    end
    else
    begin
      soft_reset_ff <= i_wr_stb && !i_ptr_load && ptr_ff == ADDR_CHIP_RESET
                       && i_wr_data[SW_RESET_BIT];
    end
  end

  // No field of this map is set-only, so every writable bit takes the byte as written.
  // A set-only field would keep its old value ORed with the written byte instead.
  generate
    for (genvar g = 0; g < NUM_RW; g++)
    begin : g_rw
      always_ff @(posedge i_ref_clk or negedge i_rst_b)
      begin
        if (!i_rst_b)
        begin
          rw_ff[g] <= RW_RESET[g];
        end
        else if (soft_reset_ff || !i_ext_reset_b)
        begin
          rw_ff[g] <= RW_RESET[g];
        end
        else if (i_wr_stb && !i_ptr_load && rw_index(ptr_ff) == g)
        begin
          rw_ff[g] <= i_wr_data;
        end
      end
    end
  endgenerate

  // ----------------------------------------------------------------------
  // Status sampling
  // ----------------------------------------------------------------------
  // Snapshots are frozen while a read byte is being fetched so each byte is whole.
  always_ff @(posedge i_ref_clk or negedge i_rst_b)
  begin
    if (!i_rst_b)
    begin
      role_rpt_ff <= ZERO_BYTE;
      conn_rpt_ff <= ZERO_BYTE;
    end
    else if (!i_rd_stb)
    begin
      role_rpt_ff <= {4'h0, i_role_speed_state & ROLE_RPT_MASK};
      conn_rpt_ff <= {5'h00, i_conn_state & CONN_RPT_MASK};
    end
  end

  // ----------------------------------------------------------------------
  // Read path
  // ----------------------------------------------------------------------
  always_comb
  begin
    nxt_rd_data = UNMAPPED_READ;
    case (ptr_ff)
      ADDR_RSVD_ZERO, ADDR_RSVD_PAIR0, ADDR_RSVD_PAIR1: nxt_rd_data = ZERO_BYTE;
      ADDR_CHIP_RESET: nxt_rd_data = ZERO_BYTE;
      ADDR_RSVD_RO: nxt_rd_data = ZERO_BYTE;
      ADDR_ROLE_RPT: nxt_rd_data = role_rpt_ff;
      ADDR_CONN_RPT: nxt_rd_data = conn_rpt_ff;
      ADDR_STEP: nxt_rd_data = STEP_CODE;
      ADDR_PART_LO: nxt_rd_data = PART_LO_CODE;
      ADDR_PART_MID: nxt_rd_data = PART_MID_CODE;
      ADDR_PART_HI: nxt_rd_data = PART_HI_CODE;
      default:
      begin
        if (rw_index(ptr_ff) < NUM_RW)
        begin
          nxt_rd_data = rw_ff[rw_index(ptr_ff)];
        end
      end
    endcase
  end

  // A read has no side effect beyond the pointer step, so write-only or set-only
  // fields could be added here without read actions.
  always_ff @(posedge i_ref_clk or negedge i_rst_b)
  begin
    if (!i_rst_b)
    begin
      rd_data_ff <= ZERO_BYTE;
    end
    else if (i_rd_stb)
    begin
      rd_data_ff <= nxt_rd_data;
    end
  end

  assign o_rd_data = rd_data_ff;
  assign o_ptr = ptr_ff;
  assign o_role_speed_forcing = rw_ff[0];
  assign o_line_state_forcing = rw_ff[1];
  assign o_embedded_side_receive_tuning = rw_ff[2];
  assign o_embedded_side_transmit_tuning = rw_ff[3];
  assign o_legacy_side_receive_tuning = rw_ff[4];
  assign o_legacy_side_emphasis_tuning = rw_ff[5];
  assign o_legacy_side_edge_swing_tuning = rw_ff[6];
  assign o_legacy_side_termination_select = rw_ff[7];
  assign o_unplug_detect_level = rw_ff[8];
  assign o_remote_access_key = rw_ff[9];
  assign o_voltage_detect_switch = rw_ff[10];

  // ----------------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------------
  // Write antecedents leave out the reset paths, because a reset in the same cycle rightly
  // overrides the write; the status checks assume one idle cycle between read strobes.
  ptr_advance_a : assert property (@(posedge i_ref_clk) disable iff (!i_rst_b)
    (i_wr_stb && !i_ptr_load && ptr_ff < LAST_ADDR) |=> ptr_ff == $past(ptr_ff) + 8'h01)
    else $error("Pointer did not advance after a byte.");

  rd_advance_a : assert property (@(posedge i_ref_clk) disable iff (!i_rst_b)
    (i_rd_stb && !i_ptr_load && ptr_ff < LAST_ADDR) |=> ptr_ff == $past(ptr_ff) + 8'h01)
    else $error("Pointer did not advance after a read.");

  ptr_load_a : assert property (@(posedge i_ref_clk) disable iff (!i_rst_b)
    i_ptr_load |=> o_ptr == $past(i_ptr_addr))
    else $error("Pointer not loaded from the address byte.");

  rw_write_a : assert property (@(posedge i_ref_clk) disable iff (!i_rst_b)
    (i_wr_stb && !i_ptr_load && ptr_ff == ADDR_EMB_RX && i_ext_reset_b && !soft_reset_ff)
    |=> o_embedded_side_receive_tuning == $past(i_wr_data))
    else $error("Written byte not stored.");

  soft_reset_a : assert property (@(posedge i_ref_clk) disable iff (!i_rst_b)
    (i_wr_stb && !i_ptr_load && ptr_ff == ADDR_CHIP_RESET && i_wr_data[SW_RESET_BIT])
    |=> ##1 (o_legacy_side_receive_tuning == RW_RESET[IDX_LEG_RX] && !soft_reset_ff))
    else $error("Software reset did not restore defaults.");

  soft_all_a : assert property (@(posedge i_ref_clk) disable iff (!i_rst_b)
    soft_reset_ff |=> (o_role_speed_forcing == RW_RESET[IDX_ROLE_SPEED]
    && o_embedded_side_receive_tuning == RW_RESET[IDX_EMB_RX]))
    else $error("Software reset missed a writable register.");

  soft_clear_a : assert property (@(posedge i_ref_clk) disable iff (!i_rst_b)
    soft_reset_ff |=> !soft_reset_ff)
    else $error("Software reset request did not clear itself.");

  zero_write_a : assert property (@(posedge i_ref_clk) disable iff (!i_rst_b)
    (i_wr_stb && !i_ptr_load && ptr_ff == ADDR_CHIP_RESET && !i_wr_data[SW_RESET_BIT])
    |=> !soft_reset_ff)
    else $error("Writing zero started a software reset.");

  ext_reset_a : assert property (@(posedge i_ref_clk) disable iff (!i_rst_b)
    !i_ext_reset_b |=> o_legacy_side_edge_swing_tuning == RW_RESET[IDX_LEG_EDGE])
    else $error("Reset pin did not restore defaults.");

  ext_hold_a : assert property (@(posedge i_ref_clk) disable iff (!i_rst_b)
    !i_ext_reset_b |=> o_embedded_side_receive_tuning == RW_RESET[IDX_EMB_RX])
    else $error("Reset pin did not hold receive tuning at default.");

  unmapped_read_a : assert property (@(posedge i_ref_clk) disable iff (!i_rst_b)
    (i_rd_stb && ptr_ff > LAST_ADDR) |=> o_rd_data == UNMAPPED_READ)
    else $error("Unmapped read not 0xFF.");

  unmapped_write_a : assert property (@(posedge i_ref_clk) disable iff (!i_rst_b)
    (i_wr_stb && !i_ptr_load && ptr_ff > LAST_ADDR && i_ext_reset_b && !soft_reset_ff)
    |=> ($stable(o_remote_access_key) && $stable(o_voltage_detect_switch)))
    else $error("Unmapped write changed a register.");

  raz_read_a : assert property (@(posedge i_ref_clk) disable iff (!i_rst_b)
    (i_rd_stb && (ptr_ff == ADDR_RSVD_ZERO || ptr_ff == ADDR_CHIP_RESET)) |=> o_rd_data == ZERO_BYTE)
    else $error("Zero field read non zero.");

  raz_write_a : assert property (@(posedge i_ref_clk) disable iff (!i_rst_b)
    (i_wr_stb && !i_ptr_load && ptr_ff == ADDR_RSVD_ZERO && i_ext_reset_b && !soft_reset_ff)
    |=> ($stable(o_role_speed_forcing) && $stable(o_line_state_forcing)))
    else $error("Write to a zero field changed a register.");

  status_read_a : assert property (@(posedge i_ref_clk) disable iff (!i_rst_b)
    (i_rd_stb && ptr_ff == ADDR_ROLE_RPT) |=> o_rd_data == {4'h0, $past(i_role_speed_state, 2)})
    else $error("Status byte not the sampled state.");

  status_conn_a : assert property (@(posedge i_ref_clk) disable iff (!i_rst_b)
    (i_rd_stb && ptr_ff == ADDR_CONN_RPT) |=> o_rd_data == {5'h00, $past(i_conn_state, 2)})
    else $error("Link status byte not the sampled state.");

  ro_hold_a : assert property (@(posedge i_ref_clk) disable iff (!i_rst_b)
    (i_rd_stb && ptr_ff == ADDR_PART_LO) |=> o_rd_data == PART_LO_CODE)
    else $error("Read-only byte changed.");

  ro_write_a : assert property (@(posedge i_ref_clk) disable iff (!i_rst_b)
    (i_wr_stb && !i_ptr_load && ptr_ff >= ADDR_ROLE_RPT && i_ext_reset_b && !soft_reset_ff)
    |=> ($stable(o_unplug_detect_level) && $stable(o_remote_access_key) && $stable(o_voltage_detect_switch)))
    else $error("Host write to a read-only byte changed a register.");

  read_stable_a : assert property (@(posedge i_ref_clk) disable iff (!i_rst_b)
    (!i_rd_stb && !i_ext_reset_b == 1'b0 && !soft_reset_ff && !i_wr_stb)
    |=> $stable(o_role_speed_forcing))
    else $error("Register changed without a write.");

  rd_hold_a : assert property (@(posedge i_ref_clk) disable iff (!i_rst_b)
    !i_rd_stb |=> $stable(o_rd_data))
    else $error("Read byte changed without a read strobe.");

endmodule
`default_nettype wire

/* dv/cfg_bus_host.sv */
// Partner model: the I2C target engine side that hands bytes to the register bank.
// Assumes one clock shared with the bank; strobes change on the falling edge.
`default_nettype none
module cfg_bus_host
(
  input wire logic i_clk,
  input wire logic [7:0] i_rd_data,
  output var logic o_ptr_load,
  output var logic [7:0] o_ptr_addr,
  output var logic o_wr_stb,
  output var logic [7:0] o_wr_data,
  output var logic o_rd_stb
);
  timeunit 1ns;
  timeprecision 1ps;
  initial
  begin
    o_ptr_load = 1'b0;
    o_ptr_addr = 8'h00;
    o_wr_stb = 1'b0;
    o_wr_data = 8'h00;
    o_rd_stb = 1'b0;
  end
  // Released buses show the inverse so a stale byte is never mistaken for a good one.
  task automatic load(input logic [7:0] a);
    @(negedge i_clk);
    o_ptr_load = 1'b1;
    o_ptr_addr = a;
    @(negedge i_clk);
    o_ptr_load = 1'b0;
    o_ptr_addr = ~a;
  endtask
  task automatic wr(input logic [7:0] d);
    @(negedge i_clk);
    o_wr_stb = 1'b1;
    o_wr_data = d;
    @(negedge i_clk);
    o_wr_stb = 1'b0;
    o_wr_data = ~d;
  endtask
  task automatic rd(output logic [7:0] d);
    @(negedge i_clk);
    o_rd_stb = 1'b1;
    @(negedge i_clk);
    o_rd_stb = 1'b0;
    d = i_rd_data;
  endtask
endmodule
`default_nettype wire

/* dv/repeater_config_register_bank_tb_top.sv */
// Testbench for the repeater register bank: defaults, access kinds, resets, pointer.
// Assumes the bus host model drives all byte strobes.
`default_nettype none
module repeater_config_register_bank_tb_top
  import repeater_cfg_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  // Identity codes handed to the bank; the values are arbitrary.
  localparam logic [7:0] STEP_ID = 8'h3c;
  localparam logic [7:0] PART_LO_ID = 8'h7e;
  localparam logic [7:0] PART_MID_ID = 8'h9b;
  localparam logic [7:0] PART_HI_ID = 8'h06;
  logic clk = 1'b0;
  logic rst_b = 1'b0;
  logic ext_b = 1'b1;
  logic [3:0] role = 4'ha;
  logic [2:0] conn = 3'h5;
  logic ptr_load, wr_stb, rd_stb;
  logic [7:0] ptr_addr, wr_data, rd_data, ptr, d;
  logic [7:0] role_frc, line_frc, emb_rx, emb_tx, leg_rx, leg_emph, leg_edge, leg_term, unplug, acc_key, vdet;
  logic [7:0] outs [NUM_RW];
  int n_errors = 0;
  int checks_done = 0;
  int cycles = 0;
  always #4 clk = ~clk;
  cfg_bus_host u_host (.i_clk(clk), .i_rd_data(rd_data), .o_ptr_load(ptr_load), .o_ptr_addr(ptr_addr),
    .o_wr_stb(wr_stb), .o_wr_data(wr_data), .o_rd_stb(rd_stb));
  repeater_cfg_regs #(.STEP_CODE(STEP_ID), .PART_LO_CODE(PART_LO_ID), .PART_MID_CODE(PART_MID_ID),
    .PART_HI_CODE(PART_HI_ID)) u_dut (.i_ref_clk(clk), .i_rst_b(rst_b), .i_ext_reset_b(ext_b),
    .i_ptr_load(ptr_load), .i_ptr_addr(ptr_addr), .i_wr_stb(wr_stb), .i_wr_data(wr_data), .i_rd_stb(rd_stb),
    .i_role_speed_state(role), .i_conn_state(conn), .o_rd_data(rd_data), .o_ptr(ptr),
    .o_role_speed_forcing(role_frc), .o_line_state_forcing(line_frc), .o_embedded_side_receive_tuning(emb_rx),
    .o_embedded_side_transmit_tuning(emb_tx), .o_legacy_side_receive_tuning(leg_rx),
    .o_legacy_side_emphasis_tuning(leg_emph), .o_legacy_side_edge_swing_tuning(leg_edge),
    .o_legacy_side_termination_select(leg_term), .o_unplug_detect_level(unplug),
    .o_remote_access_key(acc_key), .o_voltage_detect_switch(vdet));
  always_comb
  begin
    outs = '{role_frc, line_frc, emb_rx, emb_tx, leg_rx, leg_emph, leg_edge, leg_term, unplug, acc_key, vdet};
  end
  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    checks_done++;
    if (seen !== exp)
    begin
      n_errors++;
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic summarize;
    $display("checks %0d mismatches %0d", checks_done, n_errors);
    if (n_errors == 0 && checks_done > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask
  task automatic t_defaults;
    for (int i = 0; i < NUM_RW; i++)
    begin
      check(outs[i], RW_RESET[i]);
      u_host.load(RW_ADDR[i]);
      u_host.rd(d);
      check(d, RW_RESET[i]);
    end
    $display("test defaults done");
  endtask
  task automatic t_rw_seq;
    for (int i = 0; i < NUM_RW; i++)
    begin
      if (i == 0 || i == 9)
        u_host.load(RW_ADDR[i]);
      u_host.wr(~RW_RESET[i]);
      check(outs[i], ~RW_RESET[i]);
    end
    check(ptr, 8'h0f);
    u_host.load(8'h02);
    for (int i = 0; i < 9; i++)
    begin
      u_host.rd(d);
      check(d, ~RW_RESET[i]);
    end
    $display("test read write done");
  endtask
  task automatic t_fixed;
    logic [7:0] exp;
    role = 4'h3;
    conn = 3'h6;
    u_host.load(8'h00);
    u_host.wr(8'hff);
    u_host.wr(8'hff);
    u_host.load(8'h00);
    u_host.rd(d);
    check(d, 8'h00);
    u_host.rd(d);
    check(d, 8'h00);
    u_host.load(8'h0b);
    for (int i = 0; i < 14; i++)
      u_host.wr(8'hff);
    u_host.load(8'h0b);
    for (int a = 8'h0b; a < 8'h18; a++)
    begin
      case (a)
        8'h0b, 8'h11, 8'h12: exp = 8'h00;
        8'h0f: exp = {4'h0, role};
        8'h10: exp = {5'h00, conn};
        8'h13: exp = STEP_ID;
        8'h14: exp = PART_LO_ID;
        8'h15: exp = PART_MID_ID;
        8'h16: exp = PART_HI_ID;
        default: exp = 8'hff;
      endcase
      u_host.rd(d);
      check(d, exp);
    end
    role = 4'hc;
    conn = 3'h1;
    u_host.load(ADDR_ROLE_RPT);
    u_host.rd(d);
    check(d, {4'h0, role});
    u_host.rd(d);
    check(d, {5'h00, conn});
    $display("test fixed bytes done");
  endtask
  task automatic t_resets;
    u_host.load(8'h02);
    for (int i = 0; i < 9; i++)
      u_host.wr(~RW_RESET[i]);
    u_host.load(8'h01);
    u_host.wr(8'h00);
    repeat (2) @(negedge clk);
    for (int i = 0; i < 9; i++)
      check(outs[i], ~RW_RESET[i]);
    u_host.load(8'h01);
    u_host.wr(8'h01);
    repeat (2) @(negedge clk);
    for (int i = 0; i < NUM_RW; i++)
      check(outs[i], RW_RESET[i]);
    u_host.load(8'h02);
    u_host.wr(8'h3c);
    check(outs[0], 8'h3c);
    ext_b = 1'b0;
    repeat (2) @(negedge clk);
    ext_b = 1'b1;
    check(outs[0], RW_RESET[0]);
    $display("test resets done");
  endtask
  always @(posedge clk)
  begin
    cycles++;
    if (cycles == 3000)
    begin
      n_errors++;
      summarize();
    end
  end
  initial
  begin
    repeat (10) @(negedge clk);
    rst_b = 1'b1;
    t_defaults();
    t_rw_seq();
    t_fixed();
    t_resets();
    summarize();
  end
endmodule
`default_nettype wire

/* shared/repeater_cfg_pkg.sv */
// Package for the repeater configuration register bank: offsets, resets, field layout.
// Assumes the byte-wide access port of an I2C target engine outside this bank.
`default_nettype none
package repeater_cfg_pkg;
  // ----------------------------------------------------------------------
  // Register offsets
  // ----------------------------------------------------------------------
  localparam logic [7:0] ADDR_RSVD_ZERO = 8'h00;
  localparam logic [7:0] ADDR_CHIP_RESET = 8'h01;
  localparam logic [7:0] ADDR_ROLE_SPEED = 8'h02;
  localparam logic [7:0] ADDR_LINE_STATE = 8'h03;
  localparam logic [7:0] ADDR_EMB_RX = 8'h04;
  localparam logic [7:0] ADDR_EMB_TX = 8'h05;
  localparam logic [7:0] ADDR_LEG_RX = 8'h06;
  localparam logic [7:0] ADDR_LEG_EMPH = 8'h07;
  localparam logic [7:0] ADDR_LEG_EDGE = 8'h08;
  localparam logic [7:0] ADDR_LEG_TERM = 8'h09;
  localparam logic [7:0] ADDR_UNPLUG = 8'h0a;
  localparam logic [7:0] ADDR_RSVD_RO = 8'h0b;
  localparam logic [7:0] ADDR_ACCESS_KEY = 8'h0d;
  localparam logic [7:0] ADDR_VDET = 8'h0e;
  localparam logic [7:0] ADDR_ROLE_RPT = 8'h0f;
  localparam logic [7:0] ADDR_CONN_RPT = 8'h10;
  localparam logic [7:0] ADDR_RSVD_PAIR0 = 8'h11;
  localparam logic [7:0] ADDR_RSVD_PAIR1 = 8'h12;
  localparam logic [7:0] ADDR_STEP = 8'h13;
  localparam logic [7:0] ADDR_PART_LO = 8'h14;
  localparam logic [7:0] ADDR_PART_MID = 8'h15;
  localparam logic [7:0] ADDR_PART_HI = 8'h16;
  // ----------------------------------------------------------------------
  // Writable register table, index order matches the offsets 0x02..0x0a, 0x0d, 0x0e
  // ----------------------------------------------------------------------
  localparam int NUM_RW = 11;
  localparam logic [7:0] RW_ADDR [NUM_RW] = '{8'h02, 8'h03, 8'h04, 8'h05, 8'h06, 8'h07,
                                               8'h08, 8'h09, 8'h0a, 8'h0d, 8'h0e};
  localparam logic [7:0] RW_RESET [NUM_RW] = '{8'h00, 8'h00, 8'h20, 8'h10, 8'h50, 8'h00,
                                                8'h62, 8'h02, 8'h00, 8'h00, 8'h00};
  localparam int IDX_ROLE_SPEED = 0;
  localparam int IDX_EMB_RX = 2;
  localparam int IDX_LEG_RX = 4;
  localparam int IDX_LEG_EDGE = 6;
  // ----------------------------------------------------------------------
  // Fields and fixed answers
  // ----------------------------------------------------------------------
  localparam int SW_RESET_BIT = 0;
  localparam logic [7:0] UNMAPPED_READ = 8'hff;
  localparam logic [7:0] ZERO_BYTE = 8'h00;
  localparam logic [7:0] LAST_ADDR = 8'h16;
  localparam logic [3:0] ROLE_RPT_MASK = 4'hf;
  localparam logic [2:0] CONN_RPT_MASK = 3'h7;
  // Register access kinds, listed for reference; the decode and the checks do not use them.
  typedef enum logic [2:0]
  {
    ACC_RW = 3'b000,
    ACC_RO = 3'b001,
    ACC_WO = 3'b010,
    ACC_RAZ = 3'b011,
    ACC_SET = 3'b100,
    ACC_NONE = 3'b101
  } access_kind_t;
endpackage
`default_nettype wire
